// ---- aic_cmd_ctrl.sv ----
// Purpose: Decodes idle immediate, geometry load and queued non-data commands.
// Assumes: Task-file inputs are on core_clk; only the spindle speed pin is asynchronous.
// Notes:   Opcodes outside this set are left to other decoders and get no answer here.
`default_nettype none

// Summary of operation
// - Opcode E1h or 95h enters idle mode.
// - Spin up only when the spindle is stopped.
// - Idle keeps the spindle turning, commands accepted.
// - Idle immediate leaves standby timeout untouched.
// - Opcode 91h loads sectors and heads minus one.
// - Identify words 54 to 58 show geometry.
// - Geometry persists unless reloaded or reverting reset.
// - Zero sectors per track means zero.
// - Heads minus one is four bits, 0-15.
// - Opcode 63h runs subcommand-specific queued control.
// - Subcommands 0h abort and 1h deadline supported.
// - Feature 3:0 subcommand, 7:4 abort type.
// - Unsupported abort type reports command aborted.
module aic_cmd_ctrl #(
    parameter logic [15:0] ABORT_TYPES_SUPPORTED = 16'h000F,
    parameter logic [4:0]  QUEUE_DEPTH_MAX       = 5'h1F,
    parameter logic [15:0] CYLINDERS             = aic_pkg::DEF_CYL
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [7:0]  cmd_feature,
    input  wire logic [7:0]  cmd_sector_count,
    input  wire logic [7:0]  cmd_sector_number,
    input  wire logic [7:0]  cmd_device_head,
    input  wire logic        ncq_enable,
    input  wire logic        soft_reset_pulse,
    input  wire logic        set_feature_valid,
    input  wire logic [7:0]  set_feature_code,
    input  wire logic        timer_load_valid,
    input  wire logic [7:0]  timer_load_value,
    input  wire logic        power_standby_req,
    input  wire logic        spindle_at_speed,
    input  wire logic [7:0]  ident_word_addr,
    output logic      [7:0]  drive_status_flags,
    output logic      [7:0]  command_error_flags,
    output logic             cmd_done,
    output logic             power_idle,
    output logic             spindle_motor_on,
    output logic             spin_up_start,
    output logic      [7:0]  standby_timeout,
    output logic             ncq_abort_req,
    output logic      [3:0]  ncq_abort_type,
    output logic      [4:0]  ncq_abort_ttag,
    output logic             ncq_deadline_req,
    output logic      [7:0]  geom_sectors_per_track,
    output logic      [3:0]  geom_heads_m1,
    output logic      [15:0] ident_word_data
);

    aic_pkg::aic_state_t state_reg;
    logic [7:0]  status_reg;
    logic [7:0]  error_reg;
    logic        result_err_reg;
    logic        done_reg;
    logic        idle_reg;
    logic        motor_reg;
    logic        spin_start_reg;
    logic [7:0]  timer_reg;
    logic        abort_req_reg;
    logic [3:0]  abort_type_reg;
    logic [4:0]  abort_ttag_reg;
    logic        deadline_reg;
    logic        revert_reg;
    logic        speed_meta_reg;
    logic        speed_sync_reg;

    logic        is_idle;
    logic        is_geom;
    logic        is_ncq;
    logic        take;
    logic [3:0]  subcmd;
    logic [3:0]  abort_type;
    logic [4:0]  tag;
    logic [4:0]  ttag;
    logic        abort_bad;
    logic        ncq_reject;
    logic        geom_load;
    logic        geom_revert;

    // The speed pin comes from the motor controller on its own timing.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            speed_meta_reg <= 1'b0;
            speed_sync_reg <= 1'b0;
        end else begin
            speed_meta_reg <= spindle_at_speed;
            speed_sync_reg <= speed_meta_reg;
        end
    end

    always_comb begin
        is_idle    = (cmd_opcode == aic_pkg::OPC_IDLE_IMM) ||
                     (cmd_opcode == aic_pkg::OPC_IDLE_IMM_ALT);
        is_geom    = (cmd_opcode == aic_pkg::OPC_INIT_GEOM);
        is_ncq     = (cmd_opcode == aic_pkg::OPC_NCQ_NONDATA);
        take       = (state_reg == aic_pkg::AIC_ST_READY) && cmd_valid &&
                     (is_idle || is_geom || is_ncq);
        subcmd     = cmd_feature[aic_pkg::SUBCMD_MSB:aic_pkg::SUBCMD_LSB];
        abort_type = cmd_feature[aic_pkg::ABTYPE_MSB:aic_pkg::ABTYPE_LSB];
        tag        = cmd_sector_count[aic_pkg::TAG_MSB:aic_pkg::TAG_LSB];
        ttag       = cmd_sector_number[aic_pkg::TAG_MSB:aic_pkg::TAG_LSB];
        // The target tag only matters for the selected-command abort type.
        abort_bad  = !ncq_enable || !ABORT_TYPES_SUPPORTED[abort_type] ||
                     ((abort_type == aic_pkg::ABORT_TYPE_SELECTED) &&
                      ((ttag == tag) || (ttag > QUEUE_DEPTH_MAX)));
        unique case (subcmd)
            aic_pkg::SUBCMD_ABORT:    ncq_reject = abort_bad;
            aic_pkg::SUBCMD_DEADLINE: ncq_reject = 1'b0;
            default:                  ncq_reject = 1'b1;
        endcase
        geom_load   = take && is_geom;
        geom_revert = soft_reset_pulse && revert_reg;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= aic_pkg::AIC_ST_READY;
            result_err_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                aic_pkg::AIC_ST_READY: begin
                    if (take) begin
                        result_err_reg <= is_ncq && ncq_reject;
                        if (is_idle && !speed_sync_reg) begin
                            state_reg <= aic_pkg::AIC_ST_SPIN;
                        end else begin
                            state_reg <= aic_pkg::AIC_ST_FINISH;
                        end
                    end
                end
                aic_pkg::AIC_ST_SPIN: begin
                    if (speed_sync_reg) begin
                        state_reg <= aic_pkg::AIC_ST_FINISH;
                    end
                end
                aic_pkg::AIC_ST_FINISH: begin
                    state_reg <= aic_pkg::AIC_ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= aic_pkg::STATUS_RESET;
            error_reg  <= aic_pkg::ERROR_RESET;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= (state_reg == aic_pkg::AIC_ST_FINISH);
            if (take) begin
                status_reg <= aic_pkg::STATUS_BUSY;
            end else if (state_reg == aic_pkg::AIC_ST_FINISH) begin
                if (result_err_reg) begin
                    status_reg <= aic_pkg::STATUS_ERR;
                    error_reg  <= aic_pkg::ERROR_ABORT_ONLY;
                end else begin
                    status_reg <= aic_pkg::STATUS_OK;
                    error_reg  <= aic_pkg::ERROR_NONE;
                end
            end
        end
    end

    // Power mode and spindle; a standby request is only honoured between commands.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_reg       <= 1'b0;
            motor_reg      <= 1'b0;
            spin_start_reg <= 1'b0;
        end else begin
            spin_start_reg <= take && is_idle && !speed_sync_reg;
            if (take && is_idle) begin
                idle_reg  <= 1'b1;
                motor_reg <= 1'b1;
            end else if (power_standby_req && state_reg == aic_pkg::AIC_ST_READY) begin
                idle_reg  <= 1'b0;
                motor_reg <= 1'b0;
            end
        end
    end

    // Only the outside timer path writes the timeout, so idle immediate cannot disturb it.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_reg <= aic_pkg::TIMER_RESET;
        end else if (timer_load_valid) begin
            timer_reg <= timer_load_value;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            revert_reg <= aic_pkg::REVERT_RESET;
        end else if (set_feature_valid) begin
            if (set_feature_code == aic_pkg::FEAT_REVERT_ON) begin
                revert_reg <= 1'b1;
            end else if (set_feature_code == aic_pkg::FEAT_REVERT_OFF) begin
                revert_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            abort_req_reg  <= 1'b0;
            abort_type_reg <= 4'h0;
            abort_ttag_reg <= 5'h00;
            deadline_reg   <= 1'b0;
        end else begin
            abort_req_reg <= take && is_ncq && (subcmd == aic_pkg::SUBCMD_ABORT) &&
                             !abort_bad;
            deadline_reg  <= take && is_ncq && (subcmd == aic_pkg::SUBCMD_DEADLINE);
            if (take && is_ncq) begin
                abort_type_reg <= abort_type;
                abort_ttag_reg <= ttag;
            end
        end
    end

    aic_geom_store #(
        .CYLINDERS (CYLINDERS)
    ) u_geom (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .load          (geom_load),
        .load_spt      (cmd_sector_count),
        .load_heads_m1 (cmd_device_head[aic_pkg::HEADS_MSB:aic_pkg::HEADS_LSB]),
        .revert        (geom_revert),
        .ident_addr    (ident_word_addr),
        .spt           (geom_sectors_per_track),
        .heads_m1      (geom_heads_m1),
        .ident_data    (ident_word_data)
    );

    assign drive_status_flags  = status_reg;
    assign command_error_flags = error_reg;
    assign cmd_done            = done_reg;
    assign power_idle          = idle_reg;
    assign spindle_motor_on    = motor_reg;
    assign spin_up_start       = spin_start_reg;
    assign standby_timeout     = timer_reg;
    assign ncq_abort_req       = abort_req_reg;
    assign ncq_abort_type      = abort_type_reg;
    assign ncq_abort_ttag      = abort_ttag_reg;
    assign ncq_deadline_req    = deadline_reg;

    // Checks.
    sequence s_finish_ok;
        ##1 (done_reg && !status_reg[aic_pkg::STS_BSY_BIT] &&
             !status_reg[aic_pkg::STS_ERR_BIT] && error_reg == aic_pkg::ERROR_NONE);
    endsequence

    sequence s_finish_abort;
        ##1 (done_reg && status_reg[aic_pkg::STS_ERR_BIT] &&
             error_reg == aic_pkg::ERROR_ABORT_ONLY);
    endsequence

    property p_idle_enter;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_idle) |=> (idle_reg && motor_reg && status_reg == aic_pkg::STATUS_BUSY);
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

    property p_no_spin_when_turning;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_idle && speed_sync_reg) |=> !spin_start_reg ##1 done_reg;
    endproperty
    a_no_spin_when_turning: assert property (p_no_spin_when_turning)
        else $error("spin-up issued while turning");

    property p_spin_when_stopped;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_idle && !speed_sync_reg) |=> (spin_start_reg && state_reg == aic_pkg::AIC_ST_SPIN);
    endproperty
    a_spin_when_stopped: assert property (p_spin_when_stopped)
        else $error("no spin-up from stop");

    property p_idle_spinning;
        @(posedge core_clk) disable iff (!reset_n)
        idle_reg |-> motor_reg;
    endproperty
    a_idle_spinning: assert property (p_idle_spinning) else $error("idle without spindle");

    property p_timer_kept;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_idle && !timer_load_valid) |=> $stable(timer_reg);
    endproperty
    a_timer_kept: assert property (p_timer_kept) else $error("standby timeout changed");

    property p_geom_load;
        @(posedge core_clk) disable iff (!reset_n)
        geom_load |=> (geom_sectors_per_track == $past(cmd_sector_count) &&
                       geom_heads_m1 == $past(cmd_device_head[3:0])) ##1 done_reg;
    endproperty
    a_geom_load: assert property (p_geom_load) else $error("geometry not loaded");

    property p_ident_spt;
        @(posedge core_clk) disable iff (!reset_n)
        (ident_word_addr == aic_pkg::IDW_SPT) |=>
            (ident_word_data == {8'h00, $past(geom_sectors_per_track)});
    endproperty
    a_ident_spt: assert property (p_ident_spt) else $error("identify word wrong");

    property p_geom_persist;
        @(posedge core_clk) disable iff (!reset_n)
        (!geom_load && !geom_revert) |=> $stable(geom_sectors_per_track);
    endproperty
    a_geom_persist: assert property (p_geom_persist) else $error("geometry lost");

    property p_ncq_reject;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_ncq && ncq_reject) |=> (!abort_req_reg && !deadline_reg) ##0 s_finish_abort;
    endproperty
    a_ncq_reject: assert property (p_ncq_reject) else $error("bad subcommand accepted");

    property p_deadline;
        @(posedge core_clk) disable iff (!reset_n)
        (take && is_ncq && subcmd == aic_pkg::SUBCMD_DEADLINE) |=> deadline_reg ##0 s_finish_ok;
    endproperty
    a_deadline: assert property (p_deadline) else $error("deadline not handled");

    property p_geom_ok;
        @(posedge core_clk) disable iff (!reset_n)
        geom_load |=> s_finish_ok;
    endproperty
    a_geom_ok: assert property (p_geom_ok) else $error("success status wrong");

endmodule // aic_cmd_ctrl

`default_nettype wire

// ---- aic_pkg.sv ----
// Purpose: Shared constants and types for the idle, geometry and queued control command decoder.
// Assumes: Task-file fields arrive already assembled by the link layer on the core clock.
// Notes:   Status and error layouts follow the drive's task-file conventions.
`default_nettype none

package aic_pkg;

    // Opcodes handled by this block.
    localparam logic [7:0] OPC_IDLE_IMM     = 8'hE1;
    localparam logic [7:0] OPC_IDLE_IMM_ALT = 8'h95;
    localparam logic [7:0] OPC_INIT_GEOM    = 8'h91;
    localparam logic [7:0] OPC_NCQ_NONDATA  = 8'h63;

    // Queued non-data subcommands and abort types.
    localparam logic [3:0] SUBCMD_ABORT        = 4'h0;
    localparam logic [3:0] SUBCMD_DEADLINE     = 4'h1;
    localparam logic [3:0] ABORT_TYPE_SELECTED = 4'h3;

    // Field positions inside the task-file bytes.
    localparam int SUBCMD_LSB    = 0;
    localparam int SUBCMD_MSB    = 3;
    localparam int ABTYPE_LSB    = 4;
    localparam int ABTYPE_MSB    = 7;
    localparam int TAG_LSB       = 3;
    localparam int TAG_MSB       = 7;
    localparam int HEADS_LSB     = 0;
    localparam int HEADS_MSB     = 3;

    // Set-features codes that choose soft-reset behaviour.
    localparam logic [7:0] FEAT_REVERT_ON  = 8'hCC;
    localparam logic [7:0] FEAT_REVERT_OFF = 8'h66;
    localparam logic       REVERT_RESET    = 1'b0;

    // Status and error register values.
    localparam logic [7:0] STATUS_RESET     = 8'h50;
    localparam logic [7:0] STATUS_BUSY      = 8'hD0;
    localparam logic [7:0] STATUS_OK        = 8'h50;
    localparam logic [7:0] STATUS_ERR       = 8'h51;
    localparam logic [7:0] ERROR_RESET      = 8'h00;
    localparam logic [7:0] ERROR_NONE       = 8'h00;
    localparam logic [7:0] ERROR_ABORT_ONLY = 8'h04;
    localparam int         STS_BSY_BIT      = 7;
    localparam int         STS_ERR_BIT      = 0;

    // Identify words that carry the logical geometry.
    localparam logic [7:0] IDW_CYLINDERS = 8'h36;
    localparam logic [7:0] IDW_HEADS     = 8'h37;
    localparam logic [7:0] IDW_SPT       = 8'h38;
    localparam logic [7:0] IDW_CAP_LO    = 8'h39;
    localparam logic [7:0] IDW_CAP_HI    = 8'h3A;

    // Geometry after power-on or a reverting soft reset; standby timeout after power-on.
    localparam logic [7:0]  DEF_SPT      = 8'h3F;
    localparam logic [3:0]  DEF_HEADS_M1 = 4'hF;
    localparam logic [15:0] DEF_CYL      = 16'h3FFF;
    localparam logic [7:0]  TIMER_RESET  = 8'h00;

    typedef enum logic [1:0] {
        AIC_ST_READY,
        AIC_ST_SPIN,
        AIC_ST_FINISH
    } aic_state_t;

endpackage

`default_nettype wire

// ---- aic_geom_store.sv ----
// Purpose: Holds logical geometry and serves the identify words derived from it.
// Assumes: Load and revert are single-cycle strobes from the command decoder.
// Notes:   Cylinder count is a fixed parameter; no divider is built.
`default_nettype none

module aic_geom_store #(
    parameter logic [15:0] CYLINDERS = aic_pkg::DEF_CYL
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        load,
    input  wire logic [7:0]  load_spt,
    input  wire logic [3:0]  load_heads_m1,
    input  wire logic        revert,
    input  wire logic [7:0]  ident_addr,
    output logic      [7:0]  spt,
    output logic      [3:0]  heads_m1,
    output logic      [15:0] ident_data
);

    logic [7:0]  spt_reg;
    logic [3:0]  heads_reg;
    logic [15:0] ident_reg;
    logic [4:0]  heads_count;
    logic [31:0] capacity;

    // A fresh load wins over a revert landing in the same cycle.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            spt_reg   <= aic_pkg::DEF_SPT;
            heads_reg <= aic_pkg::DEF_HEADS_M1;
        end else if (load) begin
            spt_reg   <= load_spt;
            heads_reg <= load_heads_m1;
        end else if (revert) begin
            spt_reg   <= aic_pkg::DEF_SPT;
            heads_reg <= aic_pkg::DEF_HEADS_M1;
        end
    end

    assign heads_count = {1'b0, heads_reg} + 5'h01;
    assign capacity    = 32'(CYLINDERS) * 32'(heads_count) * 32'(spt_reg);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ident_reg <= 16'h0000;
        end else begin
            unique case (ident_addr)
                aic_pkg::IDW_CYLINDERS: ident_reg <= CYLINDERS;
                aic_pkg::IDW_HEADS:     ident_reg <= {11'h000, heads_count};
                aic_pkg::IDW_SPT:       ident_reg <= {8'h00, spt_reg};
                aic_pkg::IDW_CAP_LO:    ident_reg <= capacity[15:0];
                aic_pkg::IDW_CAP_HI:    ident_reg <= capacity[31:16];
                default:                ident_reg <= 16'h0000;
            endcase
        end
    end

    assign spt        = spt_reg;
    assign heads_m1   = heads_reg;
    assign ident_data = ident_reg;

endmodule // aic_geom_store

`default_nettype wire

// ---- aic_host_model.sv ----
// Purpose: Host controller model that offers task-file commands to the decoder.
// Assumes: One command at a time; the next offer waits for cmd_done.
// Notes:   Released fields show the inverse of their last value, not a kind zero.
`default_nettype none

module aic_host_model (
    input  wire logic       core_clk,
    input  wire logic       cmd_done,
    output var  logic       cmd_valid,
    output var  logic [7:0] cmd_opcode,
    output var  logic [7:0] cmd_feature,
    output var  logic [7:0] cmd_sector_count,
    output var  logic [7:0] cmd_sector_number,
    output var  logic [7:0] cmd_device_head
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmd_valid = 1'b0;
        {cmd_opcode, cmd_feature, cmd_sector_count, cmd_sector_number, cmd_device_head} = '0;
    end

    // Bounded wait, so a lost completion cannot hang the caller.
    task automatic wait_done(input int limit, output bit got);
        got = 1'b0;
        for (int i = 0; i < limit && !got; i++) begin
            @(negedge core_clk);
            if (cmd_done === 1'b1) got = 1'b1;
        end
    endtask

    // Feature low nibble carries the subcommand, high nibble the abort type.
    task automatic issue(input logic [7:0] op, ft, sc, sn, dh, input int limit,
                         output bit got);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        {cmd_opcode, cmd_feature, cmd_sector_count, cmd_sector_number, cmd_device_head}
            <= {op, ft, sc, sn, dh};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        {cmd_opcode, cmd_feature, cmd_sector_count, cmd_sector_number, cmd_device_head}
            <= ~{op, ft, sc, sn, dh};
        wait_done(limit, got);
    endtask
endmodule // aic_host_model

`default_nettype wire

// ---- test_ata_idle_geometry_ncq_ctrl_cmds.sv ----
// Purpose: Self-checking bench for the idle, geometry and queued control decoder.
// Assumes: Default parameters; spindle speed is driven by the bench.
// Notes:   Standby request stays low, since no rule here covers it.
`default_nettype none

module test_ata_idle_geometry_ncq_ctrl_cmds;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic en; logic [7:0] op, ft, sc, sn, dh, st, er;} aic_row_t;
    localparam aic_row_t ROWS [9] = '{
        '{1'b1, 8'h91, 8'h00, 8'h00, 8'h00, 8'hA3, 8'h50, 8'h00},
        '{1'b1, 8'h63, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00},
        '{1'b1, 8'h63, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00},
        '{1'b1, 8'h63, 8'h02, 8'h00, 8'h00, 8'h00, 8'h51, 8'h04},
        '{1'b1, 8'h63, 8'h40, 8'h00, 8'h00, 8'h00, 8'h51, 8'h04},
        '{1'b1, 8'h63, 8'h30, 8'h08, 8'h08, 8'h00, 8'h51, 8'h04},
        '{1'b1, 8'h63, 8'h30, 8'h08, 8'h10, 8'h00, 8'h50, 8'h00},
        '{1'b0, 8'h63, 8'h30, 8'h08, 8'h10, 8'h00, 8'h51, 8'h04},
        '{1'b1, 8'h91, 8'h00, 8'h11, 8'h00, 8'hAF, 8'h50, 8'h00}};
    localparam logic [7:0]  IDA [6] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B};
    localparam logic [15:0] IDD [6] = '{16'h3FFF, 16'h0010, 16'h0011, 16'hFEF0, 16'h0043, 16'h0000};
    logic        core_clk = 1'b0, reset_n = 1'b0, ncq_enable = 1'b1, soft_reset_pulse = 1'b0;
    logic        set_feature_valid = 1'b0, timer_load_valid = 1'b0, spindle_at_speed = 1'b0;
    logic [7:0]  set_feature_code = 8'h00, timer_load_value = 8'h00, ident_word_addr = 8'h00;
    logic        cmd_valid, cmd_done, power_idle, spindle_motor_on, spin_up_start;
    logic        ncq_abort_req, ncq_deadline_req;
    logic [7:0]  cmd_opcode, cmd_feature, cmd_sector_count, cmd_sector_number, cmd_device_head;
    logic [7:0]  drive_status_flags, command_error_flags, standby_timeout, geom_sectors_per_track;
    logic [3:0]  ncq_abort_type, geom_heads_m1;
    logic [4:0]  ncq_abort_ttag;
    logic [15:0] ident_word_data;
    int          fail_count = 0, comparisons = 0, spin_count = 0, abort_count = 0, dl_count = 0;
    bit          got;

    aic_host_model aic_host_model_i (.core_clk(core_clk), .cmd_done(cmd_done),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature),
        .cmd_sector_count(cmd_sector_count), .cmd_sector_number(cmd_sector_number),
        .cmd_device_head(cmd_device_head));

    aic_cmd_ctrl aic_cmd_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature), .cmd_sector_count(cmd_sector_count),
        .cmd_sector_number(cmd_sector_number), .cmd_device_head(cmd_device_head),
        .ncq_enable(ncq_enable), .soft_reset_pulse(soft_reset_pulse),
        .set_feature_valid(set_feature_valid), .set_feature_code(set_feature_code),
        .timer_load_valid(timer_load_valid), .timer_load_value(timer_load_value),
        .power_standby_req(1'b0), .spindle_at_speed(spindle_at_speed),
        .ident_word_addr(ident_word_addr), .drive_status_flags(drive_status_flags),
        .command_error_flags(command_error_flags), .cmd_done(cmd_done),
        .power_idle(power_idle), .spindle_motor_on(spindle_motor_on),
        .spin_up_start(spin_up_start), .standby_timeout(standby_timeout),
        .ncq_abort_req(ncq_abort_req), .ncq_abort_type(ncq_abort_type),
        .ncq_abort_ttag(ncq_abort_ttag), .ncq_deadline_req(ncq_deadline_req),
        .geom_sectors_per_track(geom_sectors_per_track), .geom_heads_m1(geom_heads_m1),
        .ident_word_data(ident_word_data));

    initial forever #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (spin_up_start === 1'b1) spin_count <= spin_count + 1;
        if (ncq_abort_req === 1'b1) abort_count <= abort_count + 1;
        if (ncq_deadline_req === 1'b1) dl_count <= dl_count + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(50 * 6000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        check({command_error_flags, drive_status_flags}, 16'h0050);
        check({geom_sectors_per_track, 4'h0, geom_heads_m1}, 16'h3F0F);
        @(posedge core_clk) reset_n <= 1'b1;
        foreach (ROWS[i]) begin
            @(posedge core_clk) ncq_enable <= ROWS[i].en;
            aic_host_model_i.issue(ROWS[i].op, ROWS[i].ft, ROWS[i].sc, ROWS[i].sn,
                                   ROWS[i].dh, 4, got);
            check(16'(got), 16'h0001);
            check({command_error_flags, drive_status_flags}, {ROWS[i].er, ROWS[i].st});
            if (ROWS[i].op == 8'h91) begin
                check({geom_sectors_per_track, geom_heads_m1}, {ROWS[i].sc, ROWS[i].dh[3:0]});
            end
        end
        check(16'(abort_count * 16 + dl_count), 16'h0021);
        check({ncq_abort_type, 7'h00, ncq_abort_ttag}, 16'h3002);
        foreach (IDA[i]) begin
            @(posedge core_clk) ident_word_addr <= IDA[i];
            repeat (2) @(posedge core_clk);
            @(negedge core_clk) check(ident_word_data, IDD[i]);
        end
        // Soft reset keeps geometry until the reverting option has been chosen.
        @(posedge core_clk) {set_feature_valid, set_feature_code} <= {1'b1, 8'hCC};
        @(posedge core_clk) set_feature_code <= 8'h66;
        @(posedge core_clk) {set_feature_valid, soft_reset_pulse} <= 2'b01;
        @(posedge core_clk) soft_reset_pulse <= 1'b0;
        @(negedge core_clk) check({geom_sectors_per_track, geom_heads_m1}, 12'h11F);
        @(posedge core_clk) {set_feature_valid, set_feature_code} <= {1'b1, 8'hCC};
        @(posedge core_clk) {set_feature_valid, soft_reset_pulse} <= 2'b01;
        @(posedge core_clk) soft_reset_pulse <= 1'b0;
        repeat (2) @(negedge core_clk);
        check({geom_sectors_per_track, geom_heads_m1}, 12'h3FF);
        @(posedge core_clk) {timer_load_valid, timer_load_value} <= {1'b1, 8'h2A};
        @(posedge core_clk) timer_load_valid <= 1'b0;
        // Stopped spindle: no completion until the motor reports speed.
        aic_host_model_i.issue(8'hE1, 8'h00, 8'h00, 8'h00, 8'hA0, 6, got);
        check({15'h0, got}, 16'h0000);
        check({drive_status_flags, 4'(spin_count), power_idle, spindle_motor_on, 2'b00},
              16'hD01C);
        @(posedge core_clk) spindle_at_speed <= 1'b1;
        aic_host_model_i.wait_done(8, got);
        check({15'h0, got}, 16'h0001);
        aic_host_model_i.issue(8'h95, 8'h00, 8'h00, 8'h00, 8'hA0, 4, got);
        check({7'h0, got, drive_status_flags}, 16'h0150);
        check({standby_timeout, 4'(spin_count), power_idle, 3'h0}, 16'h2A18);
        aic_host_model_i.issue(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 5, got);
        check({7'h0, got, drive_status_flags}, 16'h0050);
        report_and_stop();
    end
endmodule // test_ata_idle_geometry_ncq_ctrl_cmds

`default_nettype wire
